// ### hdl/rfsr_top.sv
// receive fifo status, fill flags, remaining counts and iso settings
//
// Contract
// - fill flags are read-only to the host; fifo control bits read and write
// - status register resets to zero except fields with their own value
// - full flag at printed bit 0 when no free space remains
// - almost-full flag at printed bit 1 when exactly one write remains
// - four-space flag at printed bit 4 when room for four or more
// - four-present flag at printed bit 12 when four or more held
// - almost-empty flag at printed bit 14 when exactly one held
// - empty flag at printed bit 15; data reads while empty ignored
// - packet-head bit 16 set while quadlet at data port starts a packet
// - flags forced by host only while register-test bit is set
// - writing clear bit 19 discards every fifo entry
// - size field bits 26 to 31 holds capacity, reset 32h
// - fifo state reports transmit fifo remaining at printed bits 18-23
// - fifo state reports receive fifo remaining at printed bits 26-31
// - iso control holds quadlets per block in printed bits 0-21
// - iso control holds quadlets per packet in printed bits 22-31
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module rfsr_top
    import rfsr_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic rx_push,
    input wire logic rx_push_head,
    input wire logic [31:0] rx_rd_data,
    input wire logic [REM_W-1:0] tx_fifo_remaining,
    output logic rx_fifo_pop,
    output logic rx_fifo_clear,
    output logic [QPB_W-1:0] iso_quads_per_block,
    output logic [QPP_W-1:0] iso_quads_per_packet,
    output logic irq
);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_got;
        logic w_got;
        logic [ADDR_W-1:0] waddr;
        logic [31:0] wdat;
        logic [3:0] wstb;
        logic [CW-1:0] count;
        logic [CW-1:0] wr_ptr;
        logic [CW-1:0] rd_ptr;
        logic [DEPTH-1:0] head_mark;
        logic [SIZE_W-1:0] size;
        logic [31:0] force_flags;
        logic diag_test;
        logic [QPB_W-1:0] qpb;
        logic [QPP_W-1:0] qpp;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_en;
        logic irq;
        logic pop;
        logic clear;
    } rfsr_state_t;

    localparam rfsr_state_t S_RST = '{awready: 1'b1, wready: 1'b1,
        arready: 1'b1, size: SIZE_RST, force_flags: STATUS_RST,
        default: '0};

    rfsr_state_t s_q;
    rfsr_state_t s_d;
    logic [CW-1:0] cap_w;
    logic full_w, af_w, av4_w, th4_w, ae_w, empty_w, head_w;
    logic [31:0] stat_w;
    logic [31:0] wmask;
    logic [31:0] wmrg;
    logic wr_go, clr_now, pop_now, push_now;
    logic [IRQ_W-1:0] ev;

    function automatic logic [CW-1:0] nxt(input logic [CW-1:0] p);
        nxt = (p == CW'(DEPTH - 1)) ? '0 : CW'(p + 1'b1);
    endfunction

    // ****************************************************************
    // live fill flags
    // ****************************************************************
    always_comb begin
        cap_w = (int'(s_q.size) > DEPTH) ? CW'(DEPTH) : CW'(s_q.size);
        full_w = (s_q.count >= cap_w);
        af_w = (int'(s_q.count) + 1 == int'(cap_w));
        av4_w = (int'(cap_w) - int'(s_q.count) >= FOUR_QUADS);
        th4_w = (int'(s_q.count) >= FOUR_QUADS);
        ae_w = (s_q.count == CW'(1));
        empty_w = (s_q.count == '0);
        head_w = !empty_w && s_q.head_mark[s_q.rd_ptr];
        stat_w = STATUS_RST;
        if (s_q.diag_test) begin
            stat_w = s_q.force_flags & FLAG_MASK;
        end else begin
            stat_w[B_FULL] = full_w;
            stat_w[B_AF] = af_w;
            stat_w[B_AV4] = av4_w;
            stat_w[B_TH4] = th4_w;
            stat_w[B_AE] = ae_w;
            stat_w[B_EMPTY] = empty_w;
        end
        stat_w[B_HEAD] = head_w;
        stat_w[B_CLR] = s_q.clear;
        stat_w[SIZE_LSB +: SIZE_W] = s_q.size;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.pop = 1'b0;
        s_d.clear = 1'b0;
        clr_now = 1'b0;
        pop_now = 1'b0;
        ev = '0;
        for (int i = 0; i < 32; i++) begin
            wmask[i] = s_q.wstb[i / 8];
        end
        wmrg = s_q.wdat & wmask;
        wr_go = s_q.aw_got && s_q.w_got && !s_q.bvalid;
        // write address and data, either order
        if (awvalid && s_q.awready) begin
            s_d.aw_got = 1'b1;
            s_d.awready = 1'b0;
            s_d.waddr = awaddr;
        end
        if (wvalid && s_q.wready) begin
            s_d.w_got = 1'b1;
            s_d.wready = 1'b0;
            s_d.wdat = wdata;
            s_d.wstb = wstrb;
        end
        if (wr_go) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp = RESP_OKAY;
            case (s_q.waddr)
                OFF_DIAG: begin
                    if (s_q.wstb[0]) begin
                        s_d.diag_test = s_q.wdat[DIAG_TEST_B];
                    end
                end
                OFF_STATUS: begin
                    if (s_q.diag_test) begin
                        s_d.force_flags = ((s_q.force_flags & ~wmask)
                            | wmrg) & FLAG_MASK;
                    end
                    if (wmrg[B_CLR]) begin
                        clr_now = 1'b1;
                    end
                    if (s_q.wstb[0]) begin
                        s_d.size = s_q.wdat[SIZE_LSB +: SIZE_W];
                    end
                end
                OFF_ISO: begin
                    s_d.qpb = QPB_W'(({s_q.qpb, s_q.qpp} & ~wmask | wmrg)
                        >> QPB_LSB);
                    s_d.qpp = QPP_W'(({s_q.qpb, s_q.qpp} & ~wmask | wmrg)
                        >> QPP_LSB);
                end
                OFF_IRQ_EN: begin
                    s_d.irq_en = IRQ_W'(({29'h0, s_q.irq_en} & ~wmask)
                        | wmrg);
                end
                OFF_IRQ_CLR, OFF_FSTATE, OFF_IRQ_STAT, OFF_DATA: begin
                end
                default: begin
                    s_d.bresp = RESP_SLVERR;
                end
            endcase
        end
        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
            s_d.awready = 1'b1;
            s_d.wready = 1'b1;
        end
        // read channel
        if (arvalid && s_q.arready) begin
            s_d.arready = 1'b0;
            s_d.rvalid = 1'b1;
            s_d.rresp = RESP_OKAY;
            s_d.rdata = '0;
            case (araddr)
                OFF_DIAG: s_d.rdata[DIAG_TEST_B] = s_q.diag_test;
                OFF_STATUS: s_d.rdata = stat_w;
                OFF_DATA: begin
                    if (empty_w) begin
                        ev[IRQ_UNDR] = 1'b1;
                    end else begin
                        s_d.rdata = rx_rd_data;
                        pop_now = !clr_now;
                    end
                end
                OFF_FSTATE: begin
                    s_d.rdata[TX_REM_LSB +: REM_W] = tx_fifo_remaining;
                    s_d.rdata[RX_REM_LSB +: REM_W] =
                        REM_W'(s_q.count);
                end
                OFF_ISO: s_d.rdata = {s_q.qpb, s_q.qpp};
                OFF_IRQ_STAT: s_d.rdata = 32'(s_q.irq_stat);
                OFF_IRQ_EN: s_d.rdata = 32'(s_q.irq_en);
                OFF_IRQ_CLR: s_d.rdata = '0;
                default: s_d.rresp = RESP_SLVERR;
            endcase
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
            s_d.arready = 1'b1;
        end
        // occupancy
        push_now = rx_push && !full_w && !clr_now;
        ev[IRQ_OVF] = rx_push && full_w && !clr_now;
        ev[IRQ_HEAD] = push_now && rx_push_head;
        if (clr_now) begin
            s_d.count = '0;
            s_d.wr_ptr = '0;
            s_d.rd_ptr = '0;
            s_d.head_mark = '0;
            s_d.clear = 1'b1;
        end else begin
            if (push_now) begin
                s_d.head_mark[s_q.wr_ptr] = rx_push_head;
                s_d.wr_ptr = nxt(s_q.wr_ptr);
            end
            if (pop_now) begin
                s_d.rd_ptr = nxt(s_q.rd_ptr);
                s_d.pop = 1'b1;
            end
            s_d.count = CW'(s_q.count + CW'(push_now) - CW'(pop_now));
        end
        // interrupts, set wins over clear
        s_d.irq_stat = s_q.irq_stat;
        if (wr_go && s_q.waddr == OFF_IRQ_CLR) begin
            s_d.irq_stat = s_q.irq_stat & ~IRQ_W'(wmrg);
        end
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_en);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= S_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign awready = s_q.awready;
    assign wready = s_q.wready;
    assign bvalid = s_q.bvalid;
    assign bresp = s_q.bresp;
    assign arready = s_q.arready;
    assign rvalid = s_q.rvalid;
    assign rresp = s_q.rresp;
    assign rdata = s_q.rdata;
    assign rx_fifo_pop = s_q.pop;
    assign rx_fifo_clear = s_q.clear;
    assign iso_quads_per_block = s_q.qpb;
    assign iso_quads_per_packet = s_q.qpp;
    assign irq = s_q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [CW-1:0] cnt_a;
    logic [CW-1:0] cap_a;
    assign cnt_a = s_q.count;
    assign cap_a = cap_w;

    sequence s_stat_rd;
        arvalid && arready && araddr == OFF_STATUS && !s_q.diag_test;
    endsequence

    property p_full;
        @(posedge aclk) disable iff (!aresetn)
        s_stat_rd |=> rdata[B_FULL] == ($past(cnt_a) >= $past(cap_a));
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");

    property p_af;
        @(posedge aclk) disable iff (!aresetn)
        s_stat_rd |=> rdata[B_AF] ==
            (int'($past(cnt_a)) + 1 == int'($past(cap_a)));
    endproperty
    a_af: assert property (p_af) else $error("almost full wrong");

    property p_th4;
        @(posedge aclk) disable iff (!aresetn)
        s_stat_rd |=> rdata[B_TH4] == ($past(cnt_a) >= CW'(4));
    endproperty
    a_th4: assert property (p_th4) else $error("four present wrong");

    property p_empty;
        @(posedge aclk) disable iff (!aresetn)
        s_stat_rd |=> rdata[B_EMPTY] == ($past(cnt_a) == '0)
            && rdata[B_AE] == ($past(cnt_a) == CW'(1));
    endproperty
    a_empty: assert property (p_empty) else $error("empty wrong");

    property p_empty_rd;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == OFF_DATA && cnt_a == '0
            && !rx_push |=> cnt_a == '0 && !rx_fifo_pop;
    endproperty
    a_empty_rd: assert property (p_empty_rd) else $error("empty pop");

    sequence s_clr_wr;
        wr_go && s_q.waddr == OFF_STATUS && wmrg[B_CLR];
    endsequence

    property p_clear;
        @(posedge aclk) disable iff (!aresetn)
        s_clr_wr |=> rx_fifo_clear && cnt_a == '0 ##1 !rx_fifo_clear;
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_size_rst;
        @(posedge aclk)
        !aresetn |=> s_q.size == SIZE_RST;
    endproperty
    a_size_rst: assert property (p_size_rst) else $error("size reset");

    property p_remain;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && araddr == OFF_FSTATE |=>
            rdata[RX_REM_LSB +: REM_W] == REM_W'($past(cnt_a))
            && rdata[TX_REM_LSB +: REM_W] == $past(tx_fifo_remaining);
    endproperty
    a_remain: assert property (p_remain) else $error("remain bad");

    property p_force;
        @(posedge aclk) disable iff (!aresetn)
        !s_q.diag_test && !$past(s_q.diag_test) |->
            s_q.force_flags == $past(s_q.force_flags);
    endproperty
    a_force: assert property (p_force) else $error("flag forced");

    property p_push;
        @(posedge aclk) disable iff (!aresetn)
        rx_push && !full_w && !clr_now && !pop_now |=>
            cnt_a == CW'($past(cnt_a) + 1'b1);
    endproperty
    a_push: assert property (p_push) else $error("push lost");
endmodule

// ### common/rfsr_pkg.sv
// constants for the receive fifo status and control registers
package rfsr_pkg;
    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_DIAG = 8'h20;
    localparam logic [7:0] OFF_STATUS = 8'h3C;
    localparam logic [7:0] OFF_DATA = 8'h40;
    localparam logic [7:0] OFF_FSTATE = 8'h50;
    localparam logic [7:0] OFF_ISO = 8'h54;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h60;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h64;
    localparam logic [7:0] OFF_IRQ_EN = 8'h68;
    // ****************************************************************
    // field positions, printed bit n sits at bus bit 31-n
    // ****************************************************************
    localparam int B_FULL = 31;
    localparam int B_AF = 30;
    localparam int B_AV4 = 27;
    localparam int B_TH4 = 19;
    localparam int B_AE = 17;
    localparam int B_EMPTY = 16;
    localparam int B_HEAD = 15;
    localparam int B_CLR = 12;
    localparam int SIZE_LSB = 0;
    localparam int SIZE_W = 6;
    localparam int TX_REM_LSB = 8;
    localparam int RX_REM_LSB = 0;
    localparam int REM_W = 6;
    localparam int QPB_LSB = 10;
    localparam int QPB_W = 22;
    localparam int QPP_LSB = 0;
    localparam int QPP_W = 10;
    localparam int DIAG_TEST_B = 0;
    localparam logic [31:0] FLAG_MASK = 32'hC80B0000;
    localparam int IRQ_OVF = 0;
    localparam int IRQ_UNDR = 1;
    localparam int IRQ_HEAD = 2;
    localparam int IRQ_W = 3;
    // ****************************************************************
    // reset values and answers
    // ****************************************************************
    localparam logic [31:0] STATUS_RST = 32'h00000000;
    localparam logic [SIZE_W-1:0] SIZE_RST = 6'h32;
    localparam int FIFO_DEPTH = 50;
    localparam int FOUR_QUADS = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### tb/rfsr_store_model.sv
// storage model holding the quadlets the link side writes
`timescale 1ns/1ps
module rfsr_store_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_push,
    input wire logic rx_fifo_pop,
    input wire logic rx_fifo_clear,
    output logic [31:0] rx_rd_data
);
    logic [31:0] q[$];
    logic [31:0] last;
    logic [15:0] idx;
    always @(posedge aclk) begin
        if (!aresetn) begin
            q.delete();
            idx = 16'h0000;
            last = 32'h00000000;
        end else if (rx_fifo_clear) begin
            q.delete();
        end else begin
            if (rx_fifo_pop && q.size() > 0) begin
                last = q[0];
                q.pop_front();
            end
            if (rx_push) begin
                q.push_back({16'hC0DE, idx});
                idx = idx + 16'h0001;
            end
        end
        // released head shows the inverse of the last quadlet
        rx_rd_data <= (q.size() > 0) ? q[0] : ~last;
    end
endmodule

// ### tb/test_receive_fifo_status_regs.sv
// self-checking bench for the receive fifo status registers
`timescale 1ns/1ps
module test_receive_fifo_status_regs;
    import rfsr_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic rx_push, rx_push_head, rx_fifo_pop, rx_fifo_clear;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rx_rd_data, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic [5:0] tx_fifo_remaining;
    logic [21:0] qpb;
    logic [9:0] qpp;
    int fail_count, checked;
    rfsr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .rx_push(rx_push), .rx_push_head(rx_push_head),
        .rx_rd_data(rx_rd_data), .tx_fifo_remaining(tx_fifo_remaining),
        .rx_fifo_pop(rx_fifo_pop), .rx_fifo_clear(rx_fifo_clear),
        .iso_quads_per_block(qpb), .iso_quads_per_packet(qpp), .irq(irq));
    rfsr_store_model m (.aclk(aclk), .aresetn(aresetn), .rx_push(rx_push),
        .rx_fifo_pop(rx_fifo_pop), .rx_fifo_clear(rx_fifo_clear),
        .rx_rd_data(rx_rd_data));
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        chk({30'h0, r}, {30'h0, RESP_OKAY});
        chk(d, exp);
    endtask
    task automatic push(input logic h);
        @(posedge aclk);
        rx_push <= 1'b1;
        rx_push_head <= h;
        @(posedge aclk);
        rx_push <= 1'b0;
        rx_push_head <= 1'b0;
        @(posedge aclk);
    endtask
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset();
        rchk(OFF_STATUS, 32'h08010032);
        rchk(OFF_FSTATE, 32'h00001500);
        rchk(OFF_ISO, 32'h00000000);
    endtask
    task automatic t_fill();
        push(1'b1);
        rchk(OFF_STATUS, 32'h08028032);
        rchk(OFF_FSTATE, 32'h00001501);
        push(1'b0);
        push(1'b0);
        push(1'b0);
        rchk(OFF_STATUS, 32'h08088032);
        rchk(OFF_FSTATE, 32'h00001504);
    endtask
    task automatic t_pop();
        rchk(OFF_DATA, 32'hC0DE0000);
        chk({31'h0, rx_fifo_pop}, 32'h00000001);
        rchk(OFF_STATUS, 32'h08000032);
        rchk(OFF_FSTATE, 32'h00001503);
    endtask
    task automatic t_full();
        wr(OFF_STATUS, 32'hC8030005);
        rchk(OFF_STATUS, 32'h00000005);
        push(1'b0);
        rchk(OFF_STATUS, 32'h40080005);
        push(1'b0);
        rchk(OFF_STATUS, 32'h80080005);
        push(1'b0);
        rchk(OFF_FSTATE, 32'h00001505);
    endtask
    task automatic t_force();
        wr(OFF_DIAG, 32'h00000001);
        wr(OFF_STATUS, 32'h08010005);
        rchk(OFF_STATUS, 32'h08010005);
        wr(OFF_DIAG, 32'h00000000);
        rchk(OFF_STATUS, 32'h80080005);
    endtask
    task automatic t_clear();
        wr(OFF_STATUS, 32'h00001005);
        chk({31'h0, rx_fifo_clear}, 32'h00000001);
        rchk(OFF_STATUS, 32'h08010005);
        chk({31'h0, rx_fifo_clear}, 32'h00000000);
        rchk(OFF_FSTATE, 32'h00001500);
    endtask
    task automatic t_irq();
        rchk(OFF_IRQ_STAT, 32'h00000005);
        wr(OFF_IRQ_CLR, 32'h00000007);
        rchk(OFF_IRQ_STAT, 32'h00000000);
        rchk(OFF_DATA, 32'h00000000);
        chk({31'h0, rx_fifo_pop}, 32'h00000000);
        rchk(OFF_FSTATE, 32'h00001500);
        rchk(OFF_IRQ_STAT, 32'h00000002);
        chk({31'h0, irq}, 32'h00000000);
        wr(OFF_IRQ_EN, 32'h00000002);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h00000001);
        wr(OFF_IRQ_CLR, 32'h00000002);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h00000000);
    endtask
    task automatic t_iso();
        wr(OFF_ISO, 32'hABCDE5A5);
        rchk(OFF_ISO, 32'hABCDE5A5);
        chk({10'h0, qpb}, {10'h0, 22'h2AF379});
        chk({22'h0, qpp}, {22'h0, 10'h1A5});
        rd(8'h7C);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        chk(d, 32'h00000000);
    endtask
    task automatic test_done();
        $display("errors %0d checks %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ****************************************************************
    // clock, reset and sequence
    // ****************************************************************
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        test_done();
    end
    initial begin
        fail_count = 0;
        checked = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {rx_push, rx_push_head} = 2'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h00000000;
        wstrb = 4'hF;
        tx_fifo_remaining = 6'h15;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_fill();
        t_pop();
        t_full();
        t_force();
        t_clear();
        t_irq();
        t_iso();
        test_done();
    end
endmodule
